// ---- design/flash_cmd_pkg.sv ----
// shared constants and types for the lock, erase and sleep command logic
package flash_cmd_pkg;
   localparam int CLK_NS = 10;
   // frame lengths in serial bits
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] ADDR_END = 6'h20;
   localparam logic [5:0] LOCK_END = 6'h28;
   localparam logic [5:0] BITS_SAT = 6'h29;
   localparam int SECTORS = 128;
   localparam logic [1:0] LOCK_RST = 2'h0;
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_ALL = 3'h7;
   // lock byte fields
   localparam int LK_DOWN_BIT = 1;
   localparam int LK_WRITE_BIT = 0;
   // self-timed durations, plain defaults
   localparam longint SSE_TIME_US = 64'd50000;
   localparam longint SE_TIME_US = 64'd600000;
   localparam longint BE_TIME_MS = 64'd80000;
   localparam longint DP_TIME_US = 64'd3;
   localparam longint RDP_TIME_US = 64'd30;
   localparam longint DESEL_MIN_NS = 64'd100;
   localparam int TMR_W = 40;
   localparam logic [TMR_W-1:0] SSE_CYC =
      TMR_W'(SSE_TIME_US * 1000 / CLK_NS);
   localparam logic [TMR_W-1:0] SE_CYC =
      TMR_W'(SE_TIME_US * 1000 / CLK_NS);
   localparam logic [TMR_W-1:0] BE_CYC =
      TMR_W'(BE_TIME_MS * 1000000 / CLK_NS);
   // entry and exit delays are longest waits: round down
   localparam logic [TMR_W-1:0] DP_CYC =
      TMR_W'(DP_TIME_US * 1000 / CLK_NS);
   localparam logic [TMR_W-1:0] RDP_CYC =
      TMR_W'(RDP_TIME_US * 1000 / CLK_NS);
   localparam int DESEL_CYC = int'(DESEL_MIN_NS / CLK_NS);
   typedef enum logic [1:0] {EK_SUB, EK_SECT, EK_BULK} erase_kind_type;
   typedef enum {ST_IDLE, ST_ERASE, ST_SLEEP_IN, ST_ASLEEP, ST_WAKE}
      state_type;
endpackage

// ---- design/frame_if.sv ----
// bit and frame strobes from the link sampler to the decoder
`timescale 1ns/10ps
interface frame_if;
   logic bit_stb;
   logic bit_val;
   logic cs_rise;
   logic selected;
   modport src(output bit_stb, output bit_val, output cs_rise,
      output selected);
   modport dst(input bit_stb, input bit_val, input cs_rise,
      input selected);
endinterface

// ---- design/link_sampler.sv ----
// synchronises the serial pins and finds clock and select edges
`timescale 1ns/10ps
module link_sampler (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic chip_sel_n,
   input wire logic serial_clk,
   input wire logic serial_in_line,
   frame_if.src frm
);
   logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
   logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
   logic d_s1_ff, d_s2_ff;
   logic nxt_cs_s1, nxt_cs_s2, nxt_cs_s3;
   logic nxt_ck_s1, nxt_ck_s2, nxt_ck_s3;
   logic nxt_d_s1, nxt_d_s2;

   // three stages for select and clock, two for data; clock edge and data share latency so they stay aligned
   always_comb begin
      nxt_cs_s1 = chip_sel_n;
      nxt_cs_s2 = cs_s1_ff;
      nxt_cs_s3 = cs_s2_ff;
      nxt_ck_s1 = serial_clk;
      nxt_ck_s2 = ck_s1_ff;
      nxt_ck_s3 = ck_s2_ff;
      nxt_d_s1 = serial_in_line;
      nxt_d_s2 = d_s1_ff;
   end

   // select idles high so a reset never fakes a frame end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_s1_ff <= 1'h1;
         cs_s2_ff <= 1'h1;
         cs_s3_ff <= 1'h1;
         ck_s1_ff <= 1'h0;
         ck_s2_ff <= 1'h0;
         ck_s3_ff <= 1'h0;
         d_s1_ff <= 1'h0;
         d_s2_ff <= 1'h0;
      end else begin
         cs_s1_ff <= nxt_cs_s1;
         cs_s2_ff <= nxt_cs_s2;
         cs_s3_ff <= nxt_cs_s3;
         ck_s1_ff <= nxt_ck_s1;
         ck_s2_ff <= nxt_ck_s2;
         ck_s3_ff <= nxt_ck_s3;
         d_s1_ff <= nxt_d_s1;
         d_s2_ff <= nxt_d_s2;
      end
   end

   // data is latched on the rising serial clock while selected
   assign frm.bit_stb = ck_s2_ff & ~ck_s3_ff & ~cs_s2_ff;
   assign frm.bit_val = d_s2_ff;
   assign frm.cs_rise = cs_s2_ff & ~cs_s3_ff;
   assign frm.selected = ~cs_s2_ff;
endmodule

// ---- design/cycle_timer.sv ----
// down counter for self-timed cycles and sleep delays
`timescale 1ns/10ps
module cycle_timer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [flash_cmd_pkg::TMR_W-1:0] load_val,
   output logic done
);
   logic [flash_cmd_pkg::TMR_W-1:0] cnt_ff, nxt_cnt;
   logic done_ff, nxt_done;

   // done pulses one cycle after the count reaches its last cycle
   always_comb begin
      nxt_done = 1'h0;
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt = load_val;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
         nxt_done = (cnt_ff == flash_cmd_pkg::TMR_W'(1));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         done_ff <= 1'h0;
      end else begin
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign done = done_ff;
endmodule

// ---- design/flash_lock_erase.sv ----
// command decoder for lock write, erases and deep sleep
// How it works
// - lock write and erases need the write enable latch set first
// - lock write runs only if select rises right after data bit 8
// - lock write is immediate and clears the latch in the cycle after the select rise is seen
// - lock byte: b1 lock-down, b0 write-lock, upper bits zero
// - lock write, subsector erase, sleep rejected while a cycle runs
// - subsector erase sets the whole subsector to ones
// - subsector erase needs select rise right after last address bit
// - progress flag high during erase, latch cleared before end
// - subsector erase skipped if block-protected or sector write-locked
// - sector erase needs select rise after last address bit, timed
// - sector erase skipped inside the block-protected area
// - bulk erase is opcode only, select rises after bit 8
// - bulk erase runs only with all protect bits zero
// - sleep entry is opcode only; enters after the entry delay
// - asleep, every write, program and erase is ignored
// - select high alone gives standby, never deep sleep
// - sleep state is lost at reset; comes up in standby
// - top address bit is ignored for subsector and sector erase
// - asleep only release is taken; standby after exit delay
// - all lock bits come up cleared
`timescale 1ns/10ps
module flash_lock_erase #(
   parameter logic [7:0] WR_ENABLE_OPC = 8'h01,
   parameter logic [7:0] LOCK_WRITE_OPC = 8'h02,
   parameter logic [7:0] SUB_ERASE_OPC = 8'h03,
   parameter logic [7:0] SECT_ERASE_OPC = 8'h04,
   parameter logic [7:0] BULK_ERASE_OPC = 8'h05,
   parameter logic [7:0] SLEEP_OPC = 8'h06,
   parameter logic [7:0] RELEASE_OPC = 8'h07,
   parameter logic [flash_cmd_pkg::TMR_W-1:0] SSE_CYCLES =
      flash_cmd_pkg::SSE_CYC,
   parameter logic [flash_cmd_pkg::TMR_W-1:0] SE_CYCLES =
      flash_cmd_pkg::SE_CYC,
   parameter logic [flash_cmd_pkg::TMR_W-1:0] BE_CYCLES =
      flash_cmd_pkg::BE_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic chip_sel_n,
   input wire logic serial_clk,
   input wire logic serial_in_line,
   input wire logic block_protect_0,
   input wire logic block_protect_1,
   input wire logic block_protect_2,
   input wire logic prog_cycle_busy,
   input wire logic [6:0] lock_rd_sector,
   output logic [1:0] lock_rd_bits,
   output logic write_enable_latch,
   output logic write_in_progress,
   output logic deep_sleep,
   output logic erase_start,
   output logic [1:0] erase_kind,
   output logic [22:0] erase_addr
);
   localparam int DESEL_MAX = flash_cmd_pkg::DESEL_CYC;

   frame_if frm();
   flash_cmd_pkg::state_type state_ff, nxt_state;
   logic [5:0] bits_ff, nxt_bits;
   logic [7:0] opc_ff, nxt_opc;
   logic [31:0] sr_ff, nxt_sr;
   logic wel_ff, nxt_wel;
   logic [1:0] lock_ff [flash_cmd_pkg::SECTORS];
   logic lk_we_ff, nxt_lk_we;
   logic [6:0] lk_sec_ff, nxt_lk_sec;
   logic [1:0] lk_val_ff, nxt_lk_val;
   logic [1:0] lock_rd_ff;
   logic es_ff, nxt_es;
   logic [1:0] ek_ff, nxt_ek;
   logic [22:0] ea_ff, nxt_ea;
   logic tmr_load;
   logic [flash_cmd_pkg::TMR_W-1:0] tmr_val;
   logic tmr_done;
   logic [2:0] bp;
   logic [6:0] er_sec;
   logic frame8, frame32, frame40, go;

   link_sampler i_link_sampler (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .chip_sel_n(chip_sel_n),
      .serial_clk(serial_clk),
      .serial_in_line(serial_in_line),
      .frm(frm.src)
   );

   cycle_timer i_cycle_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   // protected area grows from the top sector as the code rises
   function automatic logic bp_hit(input logic [2:0] code,
      input logic [6:0] sec);
      logic [7:0] span;
      span = 8'h00;
      if (code == flash_cmd_pkg::BP_ALL) begin
         span = 8'h80;
      end else if (code != flash_cmd_pkg::BP_NONE) begin
         span = 8'h01 << (code - 3'h1);
      end
      return {1'b0, sec} >= (8'h80 - span);
   endfunction

   assign bp = {block_protect_2, block_protect_1, block_protect_0};
   // erase address: bits 22..16 pick the sector, bit 23 dropped
   assign er_sec = sr_ff[22:16];
   // exact frame lengths; any other count at select rise is discarded
   assign frame8 = frm.cs_rise && bits_ff == flash_cmd_pkg::OPC_BITS;
   assign frame32 = frm.cs_rise && bits_ff == flash_cmd_pkg::ADDR_END;
   assign frame40 = frm.cs_rise && bits_ff == flash_cmd_pkg::LOCK_END;
   // write class commands need the latch and no foreign cycle
   assign go = wel_ff && !prog_cycle_busy;

   // serial shift: opcode first, then address and data
   always_comb begin
      nxt_bits = bits_ff;
      nxt_opc = opc_ff;
      nxt_sr = sr_ff;
      if (!frm.selected) begin
         nxt_bits = 6'h00;
      end else if (frm.bit_stb) begin
         if (bits_ff < flash_cmd_pkg::OPC_BITS) begin
            nxt_opc = {opc_ff[6:0], frm.bit_val};
         end else begin
            nxt_sr = {sr_ff[30:0], frm.bit_val};
         end
         // saturate so overlong frames never alias a valid length
         if (bits_ff != flash_cmd_pkg::BITS_SAT) begin
            nxt_bits = bits_ff + 6'h01;
         end
      end
   end

   // command execution at the end of a frame
   always_comb begin
      nxt_state = state_ff;
      nxt_wel = wel_ff;
      nxt_lk_we = 1'h0;
      nxt_lk_sec = lk_sec_ff;
      nxt_lk_val = lk_val_ff;
      nxt_es = 1'h0;
      nxt_ek = ek_ff;
      nxt_ea = ea_ff;
      tmr_load = 1'h0;
      tmr_val = '0;
      case (state_ff)
         flash_cmd_pkg::ST_IDLE: begin
            if (frame8 && opc_ff == WR_ENABLE_OPC && !prog_cycle_busy) begin
               nxt_wel = 1'h1;
            end else if (frame40 && opc_ff == LOCK_WRITE_OPC && go) begin
               // volatile store, no timed cycle; upper data bits unused
               nxt_lk_we = 1'h1;
               nxt_lk_sec = sr_ff[30:24];
               nxt_lk_val = sr_ff[1:0];
               nxt_wel = 1'h0;
            end else if (frame32 && opc_ff == SUB_ERASE_OPC && go) begin
               if (!bp_hit(bp, er_sec) &&
                  !lock_ff[er_sec][flash_cmd_pkg::LK_WRITE_BIT]) begin
                  nxt_es = 1'h1;
                  nxt_ek = flash_cmd_pkg::EK_SUB;
                  nxt_ea = sr_ff[22:0];
                  tmr_load = 1'h1;
                  tmr_val = SSE_CYCLES;
                  nxt_wel = 1'h0;
                  nxt_state = flash_cmd_pkg::ST_ERASE;
               end
            end else if (frame32 && opc_ff == SECT_ERASE_OPC && go) begin
               if (!bp_hit(bp, er_sec)) begin
                  nxt_es = 1'h1;
                  nxt_ek = flash_cmd_pkg::EK_SECT;
                  nxt_ea = sr_ff[22:0];
                  tmr_load = 1'h1;
                  tmr_val = SE_CYCLES;
                  nxt_wel = 1'h0;
                  nxt_state = flash_cmd_pkg::ST_ERASE;
               end
            end else if (frame8 && opc_ff == BULK_ERASE_OPC && go) begin
               if (bp == flash_cmd_pkg::BP_NONE) begin
                  nxt_es = 1'h1;
                  nxt_ek = flash_cmd_pkg::EK_BULK;
                  nxt_ea = '0;
                  tmr_load = 1'h1;
                  tmr_val = BE_CYCLES;
                  nxt_wel = 1'h0;
                  nxt_state = flash_cmd_pkg::ST_ERASE;
               end
            end else if (frame8 && opc_ff == SLEEP_OPC &&
               !prog_cycle_busy) begin
               // only this instruction leads to sleep; plain deselect does not
               tmr_load = 1'h1;
               tmr_val = flash_cmd_pkg::DP_CYC;
               nxt_state = flash_cmd_pkg::ST_SLEEP_IN;
            end
         end
         // all frames during the erase are dropped, cycle untouched
         flash_cmd_pkg::ST_ERASE: begin
            if (tmr_done) begin
               nxt_state = flash_cmd_pkg::ST_IDLE;
            end
         end
         flash_cmd_pkg::ST_SLEEP_IN: begin
            if (tmr_done) begin
               nxt_state = flash_cmd_pkg::ST_ASLEEP;
            end
         end
         // asleep: release is the one frame acted on
         flash_cmd_pkg::ST_ASLEEP: begin
            if (frame8 && opc_ff == RELEASE_OPC) begin
               tmr_load = 1'h1;
               tmr_val = flash_cmd_pkg::RDP_CYC;
               nxt_state = flash_cmd_pkg::ST_WAKE;
            end
         end
         flash_cmd_pkg::ST_WAKE: begin
            if (tmr_done) begin
               nxt_state = flash_cmd_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = flash_cmd_pkg::ST_IDLE;
         end
      endcase
   end

   // reset lands in standby with latch and lock bits clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= flash_cmd_pkg::ST_IDLE;
         bits_ff <= 6'h00;
         opc_ff <= 8'h00;
         sr_ff <= 32'h0000_0000;
         wel_ff <= 1'h0;
         lk_we_ff <= 1'h0;
         lk_sec_ff <= 7'h00;
         lk_val_ff <= 2'h0;
         es_ff <= 1'h0;
         ek_ff <= 2'h0;
         ea_ff <= 23'h00_0000;
      end else begin
         state_ff <= nxt_state;
         bits_ff <= nxt_bits;
         opc_ff <= nxt_opc;
         sr_ff <= nxt_sr;
         wel_ff <= nxt_wel;
         lk_we_ff <= nxt_lk_we;
         lk_sec_ff <= nxt_lk_sec;
         lk_val_ff <= nxt_lk_val;
         es_ff <= nxt_es;
         ek_ff <= nxt_ek;
         ea_ff <= nxt_ea;
      end
   end

   // lock store; written one cycle after the frame closes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < flash_cmd_pkg::SECTORS; i++) begin
            lock_ff[i] <= flash_cmd_pkg::LOCK_RST;
         end
         lock_rd_ff <= 2'h0;
      end else begin
         if (lk_we_ff) begin
            lock_ff[lk_sec_ff] <= lk_val_ff;
         end
         lock_rd_ff <= lock_ff[lock_rd_sector];
      end
   end

   assign lock_rd_bits = lock_rd_ff;
   assign write_enable_latch = wel_ff;
   assign write_in_progress = (state_ff == flash_cmd_pkg::ST_ERASE);
   assign deep_sleep = (state_ff == flash_cmd_pkg::ST_ASLEEP) ||
      (state_ff == flash_cmd_pkg::ST_WAKE);
   assign erase_start = es_ff;
   assign erase_kind = ek_ff;
   assign erase_addr = ea_ff;

   // checks on the command outcomes
   AST_WEL_SET: assert property (@(posedge ref_clk)
      disable iff (sys_rst) state_ff == flash_cmd_pkg::ST_IDLE && frame8 &&
      !prog_cycle_busy && opc_ff == WR_ENABLE_OPC |=> wel_ff)
      else $error("latch not set after write enable");
   AST_ERASE_NEEDS_WEL: assert property (@(posedge ref_clk)
      disable iff (sys_rst) $rose(es_ff) |-> $past(wel_ff, 1))
      else $error("erase started without latch");
   AST_LOCK_FRAME: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      lk_we_ff |-> $past(bits_ff) == flash_cmd_pkg::LOCK_END)
      else $error("lock write from wrong frame length");
   AST_LOCK_WEL_CLR: assert property (@(posedge ref_clk)
      disable iff (sys_rst) lk_we_ff |-> ##[0:DESEL_MAX] !wel_ff)
      else $error("latch not cleared after lock write");
   AST_BUSY_REJECT: assert property (@(posedge ref_clk)
      disable iff (sys_rst) state_ff == flash_cmd_pkg::ST_ERASE |=>
      !es_ff && !lk_we_ff)
      else $error("command accepted during erase");
   AST_ERASE_FRAME: assert property (@(posedge ref_clk)
      disable iff (sys_rst) es_ff && ek_ff != flash_cmd_pkg::EK_BULK |->
      $past(bits_ff) == flash_cmd_pkg::ADDR_END)
      else $error("erase from wrong frame length");
   AST_WIP_WEL: assert property (@(posedge ref_clk)
      disable iff (sys_rst) es_ff |-> write_in_progress && !wel_ff)
      else $error("progress or latch wrong at erase start");
   AST_BULK_PROT: assert property (@(posedge ref_clk)
      disable iff (sys_rst) es_ff && ek_ff == flash_cmd_pkg::EK_BULK |->
      $past(bp) == flash_cmd_pkg::BP_NONE)
      else $error("bulk erase with protection set");
   AST_SLEEP_QUIET: assert property (@(posedge ref_clk)
      disable iff (sys_rst) deep_sleep |-> !es_ff && !lk_we_ff &&
      !$rose(wel_ff))
      else $error("write class command acted on while asleep");

   COV_LOCK: cover property (@(posedge ref_clk) lk_we_ff);
   COV_BULK: cover property (@(posedge ref_clk)
      es_ff && ek_ff == flash_cmd_pkg::EK_BULK);
   COV_WAKE: cover property (@(posedge ref_clk)
      state_ff == flash_cmd_pkg::ST_WAKE ##1
      state_ff == flash_cmd_pkg::ST_IDLE);
endmodule

// ---- testbench/spi_host_model.sv ----
// serial host model that frames commands on select, clock and data
`timescale 1ns/10ps
module spi_host_model (
   input wire logic ref_clk,
   output logic chip_sel_n,
   output logic serial_clk,
   output logic serial_in_line
);
   localparam int HALF = 8; // 80 ns half period, 160 ns serial clock
   initial begin
      chip_sel_n = 1'b1;
      serial_clk = 1'b0;
      serial_in_line = 1'b0;
   end
   // sends bits[n-1:0] msb first; clock idles low between frames
   task automatic send(input logic [39:0] bits, input int n);
      logic last;
      last = 1'b0;
      @(posedge ref_clk);
      chip_sel_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_line <= bits[i];
         last = bits[i];
         repeat (HALF) @(posedge ref_clk);
         serial_clk <= 1'b1;
         repeat (HALF) @(posedge ref_clk);
         serial_clk <= 1'b0;
      end
      repeat (HALF) @(posedge ref_clk);
      chip_sel_n <= 1'b1;
      // released line flips so a stale level is never mistaken for data
      serial_in_line <= ~last;
      // deselect gap long enough for the answer to settle
      repeat (12) @(posedge ref_clk);
   endtask
endmodule

// ---- testbench/tb_flash_lock_erase.sv ----
// self-checking bench for the lock, erase and deep sleep command block
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   num_errors++; $display("BAD t=%0t got %0h exp %0h", $time, got, exp); \
   end end
module tb_flash_lock_erase;
   localparam logic [7:0] OP_WEN = 8'h06;
   localparam logic [7:0] OP_LK = 8'he5;
   localparam logic [7:0] OP_SSE = 8'h20;
   localparam logic [7:0] OP_SE = 8'hd8;
   localparam logic [7:0] OP_BE = 8'hc7;
   localparam logic [7:0] OP_DP = 8'hb9;
   localparam logic [7:0] OP_RDP = 8'hab;
   logic ref_clk, sys_rst, chip_sel_n, serial_clk, serial_in_line;
   logic [2:0] bp;
   logic prog_cycle_busy;
   logic [6:0] lock_rd_sector;
   logic [1:0] lock_rd_bits;
   logic write_enable_latch, write_in_progress, deep_sleep, erase_start;
   logic [1:0] erase_kind;
   logic [22:0] erase_addr;
   int num_errors = 0;
   int num_checks = 0;
   int starts = 0;
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   // opcodes chosen by the bench
   flash_lock_erase #(.WR_ENABLE_OPC(OP_WEN), .LOCK_WRITE_OPC(OP_LK),
      .SUB_ERASE_OPC(OP_SSE), .SECT_ERASE_OPC(OP_SE),
      .BULK_ERASE_OPC(OP_BE), .SLEEP_OPC(OP_DP), .RELEASE_OPC(OP_RDP),
      .SSE_CYCLES(40'd50), .SE_CYCLES(40'd400), .BE_CYCLES(40'd100)
   ) i_flash_lock_erase (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
      .serial_in_line(serial_in_line), .block_protect_0(bp[0]),
      .block_protect_1(bp[1]), .block_protect_2(bp[2]),
      .prog_cycle_busy(prog_cycle_busy), .lock_rd_sector(lock_rd_sector),
      .lock_rd_bits(lock_rd_bits), .write_enable_latch(write_enable_latch),
      .write_in_progress(write_in_progress), .deep_sleep(deep_sleep),
      .erase_start(erase_start), .erase_kind(erase_kind),
      .erase_addr(erase_addr));
   spi_host_model i_spi_host_model (.ref_clk(ref_clk),
      .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
      .serial_in_line(serial_in_line));
   // counts erase start pulses; the pulse lasts a single cycle
   always @(posedge ref_clk) begin
      if (erase_start === 1'b1) starts <= starts + 1;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic op(input logic [7:0] opc, input int n);
      i_spi_host_model.send({32'h0, opc} << (n - 8), n);
   endtask
   task automatic cmd(input logic [7:0] opc, input logic [23:0] a);
      i_spi_host_model.send({8'h0, opc, a}, 32);
   endtask
   task automatic write_enable_cmd();
      op(OP_WEN, 8);
      `CHK(write_enable_latch, 1'b1)
   endtask
   // bounded wait for progress (sel 0) or sleep (sel 1) to reach lvl
   task automatic wait_lvl(input int sel, input logic lvl, input int lim);
      int k;
      k = 0;
      while (((sel == 0) ? write_in_progress : deep_sleep) !== lvl
         && k < lim) begin
         @(posedge ref_clk);
         k++;
      end
   endtask
   task automatic t_reset();
      `CHK(write_enable_latch, 1'b0)
      `CHK(write_in_progress, 1'b0)
      `CHK(deep_sleep, 1'b0)
      `CHK(lock_rd_bits, 2'h0)
      $display("test reset done");
   endtask
   task automatic t_lock();
      i_spi_host_model.send({OP_LK, 24'h051234, 8'h03}, 40);
      `CHK(lock_rd_bits, 2'h0)
      write_enable_cmd();
      // one bit short of the data byte
      i_spi_host_model.send({1'b0, OP_LK, 24'h051234, 7'h01}, 39);
      `CHK(lock_rd_bits, 2'h0)
      `CHK(write_enable_latch, 1'b1)
      i_spi_host_model.send({OP_LK, 24'h05ffff, 8'h03}, 40);
      `CHK(lock_rd_bits, 2'h3)
      `CHK(write_enable_latch, 1'b0)
      $display("test lock done");
   endtask
   task automatic t_busy();
      write_enable_cmd();
      @(posedge ref_clk);
      prog_cycle_busy <= 1'b1;
      i_spi_host_model.send({OP_LK, 24'h050000, 8'h00}, 40);
      `CHK(lock_rd_bits, 2'h3)
      op(OP_DP, 8);
      @(posedge ref_clk);
      prog_cycle_busy <= 1'b0;
      // a sleep entry taken here would show once its 300-cycle entry delay ends
      repeat (320) @(posedge ref_clk);
      `CHK(deep_sleep, 1'b0)
      $display("test busy done");
   endtask
   task automatic t_sector();
      int s0;
      s0 = starts;
      cmd(OP_SSE, 24'h051000);
      `CHK(starts, s0)
      cmd(OP_SE, 24'h85abcd);
      `CHK(starts, s0 + 1)
      `CHK(erase_kind, 2'(flash_cmd_pkg::EK_SECT))
      `CHK(erase_addr, 23'h05abcd)
      `CHK(write_in_progress, 1'b1)
      `CHK(write_enable_latch, 1'b0)
      op(OP_DP, 8);
      `CHK(write_in_progress, 1'b1)
      wait_lvl(0, 1'b0, 600);
      `CHK(write_in_progress, 1'b0)
      repeat (320) @(posedge ref_clk);
      `CHK(deep_sleep, 1'b0)
      $display("test sector done");
   endtask
   task automatic t_protect();
      int s0;
      s0 = starts;
      write_enable_cmd();
      bp <= 3'h7;
      cmd(OP_SSE, 24'h092000);
      `CHK(starts, s0)
      cmd(OP_SE, 24'h092000);
      `CHK(starts, s0)
      bp <= 3'h1;
      cmd(OP_SE, 24'h7f0000);
      `CHK(starts, s0)
      op(OP_BE, 8);
      `CHK(starts, s0)
      bp <= 3'h0;
      op(OP_BE, 9);
      `CHK(starts, s0)
      op(OP_BE, 8);
      `CHK(starts, s0 + 1)
      `CHK(erase_kind, 2'(flash_cmd_pkg::EK_BULK))
      wait_lvl(0, 1'b0, 300);
      `CHK(write_in_progress, 1'b0)
      write_enable_cmd();
      cmd(OP_SSE, 24'h092345);
      `CHK(starts, s0 + 2)
      `CHK(erase_kind, 2'(flash_cmd_pkg::EK_SUB))
      `CHK(erase_addr, 23'h092345)
      wait_lvl(0, 1'b0, 200);
      `CHK(write_in_progress, 1'b0)
      $display("test protect done");
   endtask
   task automatic t_sleep();
      op(OP_DP, 8);
      `CHK(deep_sleep, 1'b0)
      wait_lvl(1, 1'b1, 400);
      `CHK(deep_sleep, 1'b1)
      op(OP_WEN, 8);
      `CHK(write_enable_latch, 1'b0)
      op(OP_RDP, 8);
      `CHK(deep_sleep, 1'b1)
      wait_lvl(1, 1'b0, 3300);
      `CHK(deep_sleep, 1'b0)
      $display("test sleep done");
   endtask
   task automatic t_mid_reset();
      op(OP_DP, 8);
      wait_lvl(1, 1'b1, 400);
      do_reset();
      `CHK(deep_sleep, 1'b0)
      `CHK(lock_rd_bits, 2'h0)
      // back in standby, so a write enable is taken at once
      op(OP_WEN, 8);
      `CHK(write_enable_latch, 1'b1)
      $display("test mid reset done");
   endtask
   initial begin
      sys_rst = 1'b1;
      bp = 3'h0;
      prog_cycle_busy = 1'b0;
      lock_rd_sector = 7'h05;
      do_reset();
      t_reset();
      t_lock();
      t_busy();
      t_sector();
      t_protect();
      t_sleep();
      t_mid_reset();
      print_verdict();
   end
   // hang guard, about three times the expected run length
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      print_verdict();
   end
endmodule
